// File: rtl/ptb_timer.sv
// Periodic 16-bit timer with compare waveform output and AXI4-Lite registers.
// Overview of operation
// - Counter is sixteen bits, wraps at top.
// - Prescaler divides input clock, up to 1024.
// - Timer mode sets wrap flag each period.
// - Wrap interrupt enable is set after reset.
// - Enable bit readable; software toggles it.
// - Compare mode drives waveform onto LED pin.
// - Compare value sets period; match flag marks.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ptb_params.svh"
module ptb_timer
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`PTB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [`PTB_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`PTB_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [`PTB_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt and pin
  output logic irq,
  output logic timer_waveform_output_zero
);

  // ==========================================================================
  // Declarations
  ptb_ctrl_t primary_control_register;
  ptb_flags_t interrupt_flag_register;
  logic [1:0] int_enable;
  logic [15:0] period;
  logic [15:0] cmp0;
  logic [15:0] count;
  logic pin_out;
  logic wave;
  logic tick;
  logic [15:0] top;
  logic at_top;
  logic wrap_evt;
  logic match_evt;
  logic [`PTB_ADDR_W-1:0] wr_addr;
  logic [`PTB_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_held;
  logic w_held;
  logic wr_do;
  logic wr_hit;
  logic rd_hit;
  logic [`PTB_DATA_W-1:0] rd_word;
  logic [`PTB_DATA_W-1:0] ctrl_word;
  logic [`PTB_DATA_W-1:0] next_ctrl_word;

  // Merges the written bytes into an old word according to the byte strobes.
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order.
  assign wr_do = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_comb
  begin
    unique case (wr_addr)
      `PTB_ADDR_CTRL, `PTB_ADDR_PERIOD, `PTB_ADDR_CMP0, `PTB_ADDR_INT_CLEAR,
      `PTB_ADDR_INT_ENABLE, `PTB_ADDR_PIN_OUT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTB_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `PTB_RESP_OKAY : `PTB_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================================
  // Software-written registers.
  assign ctrl_word = {25'h0, primary_control_register.presc, 2'h0,
                      primary_control_register.mode, primary_control_register.enable};
  assign next_ctrl_word = merge_strb(ctrl_word, wr_data, wr_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_control_register.enable <= 1'b0;
      primary_control_register.mode <= PTB_MODE_TIMER;
      primary_control_register.presc <= `PTB_PRESC_RESET;
    end
    else if (wr_do && wr_addr == `PTB_ADDR_CTRL)
    begin
      primary_control_register.enable <= next_ctrl_word[`PTB_CTRL_ENABLE_BIT];
      primary_control_register.mode <= ptb_mode_t'(next_ctrl_word[`PTB_CTRL_MODE_BIT]);
      primary_control_register.presc <= next_ctrl_word[`PTB_CTRL_PRESC_MSB:`PTB_CTRL_PRESC_LSB];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period <= `PTB_PERIOD_RESET;
      cmp0 <= `PTB_PERIOD_RESET;
      pin_out <= 1'b0;
    end
    else if (wr_do)
    begin
      if (wr_addr == `PTB_ADDR_PERIOD)
        period <= 16'(merge_strb({16'h0, period}, wr_data, wr_strb));
      if (wr_addr == `PTB_ADDR_CMP0)
        cmp0 <= 16'(merge_strb({16'h0, cmp0}, wr_data, wr_strb));
      if (wr_addr == `PTB_ADDR_PIN_OUT && wr_strb[0])
        pin_out <= wr_data[0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_enable <= `PTB_INT_ENABLE_RESET;
    else if (wr_do && wr_addr == `PTB_ADDR_INT_ENABLE && wr_strb[0])
      int_enable <= wr_data[1:0];
  end

  // ==========================================================================
  // Prescaler and 16-bit counter.
  ptb_prescaler u_presc
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(primary_control_register.enable),
    .sel(primary_control_register.presc),
    .tick(tick)
  );

  assign top = (primary_control_register.mode == PTB_MODE_COMPARE) ? cmp0 : period;
  assign at_top = tick && (count == top);
  assign wrap_evt = at_top && primary_control_register.mode == PTB_MODE_TIMER;
  assign match_evt = at_top && primary_control_register.mode == PTB_MODE_COMPARE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= 16'h0000;
    else if (at_top)
      count <= 16'h0000;
    else if (tick)
      count <= count + 16'h0001;
  end

  // ==========================================================================
  // Flags: a new event wins over a simultaneous write-one clear.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flag
      logic evt;
      assign evt = (gi == `PTB_FLAG_WRAP_BIT) ? wrap_evt : match_evt;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          interrupt_flag_register[gi] <= 1'b0;
        else if (evt)
          interrupt_flag_register[gi] <= 1'b1;
        else if (wr_do && wr_addr == `PTB_ADDR_INT_CLEAR && wr_strb[0] && wr_data[gi])
          interrupt_flag_register[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(interrupt_flag_register & int_enable);
  end

  // ==========================================================================
  // Waveform toggles on each compare match; the pin follows it in compare mode.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wave <= 1'b0;
    else if (match_evt)
      wave <= ~wave;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_waveform_output_zero <= 1'b0;
    else if (primary_control_register.mode == PTB_MODE_COMPARE)
      timer_waveform_output_zero <= wave;
    else
      timer_waveform_output_zero <= pin_out;
  end

  // ==========================================================================
  // AXI4-Lite read channel.
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `PTB_ADDR_CTRL: rd_word = ctrl_word;
      `PTB_ADDR_PERIOD: rd_word = {16'h0000, period};
      `PTB_ADDR_CMP0: rd_word = {16'h0000, cmp0};
      `PTB_ADDR_COUNT: rd_word = {16'h0000, count};
      `PTB_ADDR_INT_STATUS: rd_word = {30'h0, interrupt_flag_register};
      `PTB_ADDR_INT_CLEAR: rd_word = 32'h0000_0000;
      `PTB_ADDR_INT_ENABLE: rd_word = {30'h0, int_enable};
      `PTB_ADDR_PIN_OUT: rd_word = {31'h0, pin_out};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PTB_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `PTB_RESP_OKAY : `PTB_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks.
  sequence seq_rd_ctrl;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `PTB_ADDR_CTRL;
  endsequence

  sequence seq_clear_zero;
    wr_do && wr_addr == `PTB_ADDR_INT_CLEAR && !(wr_strb[0] && wr_data[0]);
  endsequence

  chk_counter_wraps: assert property (@(posedge aclk) disable iff (!aresetn)
    at_top |=> count == 16'h0000)
    else $error("Counter did not return to zero at top.");

  chk_wrap_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wrap_evt |=> interrupt_flag_register.wrap ##1 (irq || !$past(int_enable[0])))
    else $error("Wrap event did not set flag and interrupt.");

  chk_enable_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> int_enable[0])
    else $error("Wrap interrupt enable not set after reset.");

  chk_enable_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_rd_ctrl |=> s_axi_rvalid && s_axi_rdata[0] == $past(primary_control_register.enable))
    else $error("Enable bit read back wrong.");

  chk_stopped_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    !primary_control_register.enable |=> count == $past(count))
    else $error("Counter moved while stopped.");

  chk_pin_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (primary_control_register.mode == PTB_MODE_COMPARE)[*2] |-> timer_waveform_output_zero == $past(wave))
    else $error("Pin does not follow waveform in compare mode.");

  chk_match_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    match_evt |=> interrupt_flag_register.match && wave != $past(wave) && count == 16'h0000)
    else $error("Compare match did not toggle waveform and set flag.");

  chk_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_clear_zero and interrupt_flag_register.wrap) |=> interrupt_flag_register.wrap)
    else $error("Writing zero cleared the wrap flag.");

  chk_one_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_addr == `PTB_ADDR_INT_CLEAR && wr_strb[0] && wr_data[0] && !wrap_evt)
    |=> !interrupt_flag_register.wrap)
    else $error("Writing one did not clear the wrap flag.");

endmodule

// File: pkg/ptb_params.svh
// Register offsets, field positions, reset values and timing counts of the periodic timer.
`ifndef PTB_PARAMS_SVH
`define PTB_PARAMS_SVH

// ==========================================================================
// Bus geometry
`define PTB_ADDR_W 8
`define PTB_DATA_W 32

// ==========================================================================
// Register byte offsets
`define PTB_ADDR_CTRL 8'h00
`define PTB_ADDR_PERIOD 8'h04
`define PTB_ADDR_CMP0 8'h08
`define PTB_ADDR_COUNT 8'h0C
`define PTB_ADDR_INT_STATUS 8'h10
`define PTB_ADDR_INT_CLEAR 8'h14
`define PTB_ADDR_INT_ENABLE 8'h18
`define PTB_ADDR_PIN_OUT 8'h1C

// ==========================================================================
// Field positions
`define PTB_CTRL_ENABLE_BIT 0
`define PTB_CTRL_MODE_BIT 1
`define PTB_CTRL_PRESC_LSB 4
`define PTB_CTRL_PRESC_MSB 6
`define PTB_FLAG_WRAP_BIT 0
`define PTB_FLAG_MATCH_BIT 1

// ==========================================================================
// Timing and reset values
`define PTB_CLK_HZ 125000000
`define PTB_PRESC_MAX 1024
`define PTB_PERIOD_MS 500
`define PTB_PERIOD_TICKS ((`PTB_CLK_HZ / `PTB_PRESC_MAX) * `PTB_PERIOD_MS / 1000)
`define PTB_PERIOD_RESET 16'(`PTB_PERIOD_TICKS - 1)
`define PTB_PRESC_RESET 3'h7
`define PTB_INT_ENABLE_RESET 2'h1
`define PTB_RESP_OKAY 2'h0
`define PTB_RESP_SLVERR 2'h2

`endif

// File: pkg/ptb_pkg.sv
// Types shared by the periodic timer modules.
package ptb_pkg;

  typedef enum logic
  {
    PTB_MODE_TIMER = 1'b0,
    PTB_MODE_COMPARE = 1'b1
  } ptb_mode_t;

  typedef struct packed {
    logic [2:0] presc;
    ptb_mode_t mode;
    logic enable;
  } ptb_ctrl_t;

  typedef struct packed {
    logic match;
    logic wrap;
  } ptb_flags_t;

endpackage

// File: rtl/ptb_prescaler.sv
// Clock prescaler that gives a one-cycle count enable at aclk divided by 1 to 1024.
`timescale 1ns/1ps
`include "ptb_params.svh"
module ptb_prescaler
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  // Count enable
  output logic tick
);

  logic [9:0] div_cnt;
  logic [9:0] mask;

  // ========================================================================
  // Ratio selection: 1, 2, 4, 8, 16, 64, 256, 1024.
  always_comb
  begin
    unique case (sel)
      3'h0: mask = 10'h000;
      3'h1: mask = 10'h001;
      3'h2: mask = 10'h003;
      3'h3: mask = 10'h007;
      3'h4: mask = 10'h00F;
      3'h5: mask = 10'h03F;
      3'h6: mask = 10'h0FF;
      3'h7: mask = 10'h3FF;
    endcase
  end

  // ========================================================================
  // Divider restarts whenever the timer is stopped so a start gives a full first tick.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      div_cnt <= 10'h000;
    else if ((div_cnt & mask) == mask)
      div_cnt <= 10'h000;
    else
      div_cnt <= div_cnt + 10'h001;
  end

  assign tick = run && ((div_cnt & mask) == mask);

  chk_presc_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && sel == 3'h7) |-> (div_cnt == 10'h3FF))
    else $error("Largest prescaler ratio is not 1024.");

endmodule

// File: bench/ptb_led_model.sv
// LED pin model that counts waveform edges and measures their spacing.
`timescale 1ns/1ps
module ptb_led_model
  import ptb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // LED pin
  input wire logic led,
  // Observations
  output logic [7:0] toggles,
  output logic [15:0] gap
);
  // ==========================================================================
  // Edge timing
  logic [15:0] stamp;
  logic [15:0] last;
  logic led_q;

  // The LED follows the pin; each level change is one blink edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stamp <= '0;
      last <= '0;
      led_q <= 1'b0;
      toggles <= '0;
      gap <= '0;
    end
    else
    begin
      stamp <= stamp + 16'h1;
      led_q <= led;
      if (led !== led_q)
      begin
        toggles <= toggles + 8'h1;
        gap <= stamp - last;
        last <= stamp;
      end
    end
  end
endmodule

// File: bench/tb_ptb_timer.sv
// Self-checking bench for the periodic timer over its register bus.
`timescale 1ns/1ps
`include "ptb_params.svh"
module tb_ptb_timer
  import ptb_pkg::*;
;
  // ==========================================================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, led;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [7:0] toggles;
  logic [15:0] gap;
  int err_total = 0;
  int checks = 0;
  int ratio [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  int base;

  always #4 aclk = ~aclk;

  ptb_timer ptb_timer_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .timer_waveform_output_zero(led));

  ptb_led_model ptb_led_model_i (.aclk(aclk), .aresetn(aresetn), .led(led), .toggles(toggles), .gap(gap));

  // ==========================================================================
  // Reporting
  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("unexpected wait expected answer seen timeout");
    end_of_test();
  endtask

  // ==========================================================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bready !== 1'b0 || n == 0)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        break;
      end
      if (n > 50)
        hang();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string nm);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n <= 51)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        chk(nm, rdata, exp);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        break;
      end
      if (n > 50)
        hang();
    end
  endtask

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v)
    begin
      @(posedge aclk);
      n++;
      if (n > 100)
        hang();
    end
    chk("irq", {31'h0, irq}, {31'h0, v});
  endtask

  task automatic wait_tog(input int k);
    int n;
    n = 0;
    while (int'(toggles) < k)
    begin
      @(posedge aclk);
      n++;
      if (n > 20000)
        hang();
    end
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`PTB_ADDR_CTRL, 32'h70, 2'h0, "ctrl");
    rchk(`PTB_ADDR_PERIOD, {16'h0, `PTB_PERIOD_RESET}, 2'h0, "period");
    rchk(`PTB_ADDR_INT_ENABLE, 32'h1, 2'h0, "int_enable");
    rchk(`PTB_ADDR_INT_STATUS, 32'h0, 2'h0, "status");
    rchk(8'h20, 32'h0, 2'h2, "unmapped");
    wr(8'h24, 32'h1, 2'h2);
    wr(`PTB_ADDR_PERIOD, 32'h0001FFFF, 2'h0);
    rchk(`PTB_ADDR_PERIOD, 32'hFFFF, 2'h0, "period16");
    // Timer mode with a short period and no division.
    wr(`PTB_ADDR_PERIOD, 32'h3, 2'h0);
    wr(`PTB_ADDR_CTRL, 32'h1, 2'h0);
    rchk(`PTB_ADDR_CTRL, 32'h1, 2'h0, "ctrl_on");
    wait_irq(1'b1);
    rchk(`PTB_ADDR_INT_STATUS, 32'h1, 2'h0, "status_wrap");
    wr(`PTB_ADDR_CTRL, 32'h0, 2'h0);
    rchk(`PTB_ADDR_CTRL, 32'h0, 2'h0, "ctrl_off");
    wr(`PTB_ADDR_INT_CLEAR, 32'h0, 2'h0);
    rchk(`PTB_ADDR_INT_STATUS, 32'h1, 2'h0, "status_kept");
    wr(`PTB_ADDR_INT_CLEAR, 32'h1, 2'h0);
    rchk(`PTB_ADDR_INT_STATUS, 32'h0, 2'h0, "status_clr");
    wait_irq(1'b0);
    wr(`PTB_ADDR_PIN_OUT, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    chk("led", {31'h0, led}, 32'h1);
    wr(`PTB_ADDR_PIN_OUT, 32'h0, 2'h0);
    // Compare mode: each prescaler ratio sets the blink spacing.
    // The top matches the old period so the frozen count never lies above it.
    wr(`PTB_ADDR_CMP0, 32'h3, 2'h0);
    for (int s = 0; s < 8; s++)
    begin
      base = int'(toggles);
      wr(`PTB_ADDR_CTRL, 32'(s * 16 + 3), 2'h0);
      wait_tog(base + 3);
      chk("gap", {16'h0, gap}, 32'(4 * ratio[s]));
      wr(`PTB_ADDR_CTRL, 32'(s * 16 + 2), 2'h0);
    end
    rchk(`PTB_ADDR_INT_STATUS, 32'h2, 2'h0, "status_match");
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(`PTB_ADDR_INT_ENABLE, 32'h3, 2'h0);
    wait_irq(1'b1);
    wr(`PTB_ADDR_INT_CLEAR, 32'h2, 2'h0);
    wait_irq(1'b0);
    end_of_test();
  end
endmodule
